// ===== verilog/fach_map.vh
// Constants for the framed ASCII command handler
`ifndef FACH_MAP_VH
`define FACH_MAP_VH
`define FACH_CH_COLON     8'h3A
`define FACH_CH_CR        8'h0D
`define FACH_CH_LF        8'h0A
`define FACH_CH_ESC       8'h1B
`define FACH_CH_Y         8'h59
`define FACH_CH_Z         8'h5A
`define FACH_CH_S         8'h53
`define FACH_CH_QM        8'h3F
`define FACH_CH_SP        8'h20
`define FACH_CH_ZERO      8'h30
`define FACH_CASE_MASK    8'hDF
`define FACH_ST_00        8'h00
`define FACH_ST_01        8'h01
`define FACH_ST_08        8'h08
`define FACH_ST_09        8'h09
`define FACH_ST_10        8'h10
`define FACH_ST_11        8'h11
`define FACH_ST_14        8'h14
`define FACH_CLK_HZ       40000000
`define FACH_TIMEOUT_MS   2000
`define FACH_TIMEOUT_CYC  ((`FACH_CLK_HZ / 1000) * `FACH_TIMEOUT_MS)
`define FACH_RESP_MS      160
`define FACH_RESP_CYC     ((`FACH_CLK_HZ / 1000) * `FACH_RESP_MS)
`define FACH_GATE_UNIT    1'b0
`define FACH_GATE_PRINTER 1'b1
`endif

// ===== verilog/fach_fifo.v
// Parameterised valid/ready FIFO for the response byte path
`timescale 1ns/1ps
`default_nettype none
module fach_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;

  // --------------------
  // Honest full and empty
  // --------------------
  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers and occupancy
  always @(posedge clk) begin
    if (!rst_n) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_data;
        wp_reg          <= wp_reg + 1'b1;
      end
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Head word presented combinationally from storage
  always @* begin
    out_data = mem_reg[rp_reg];
  end
endmodule
`default_nettype wire

// ===== verilog/fach_top.v
// Framed ASCII command interpreter with printer gate control
//
// Overview of operation
// R01 - ESC ESC Y connects hand-held to unit; ESC ESC Z to printer.
// R02 - At delivery finish: gate to hand-held, finish command, send ID S08.
// R03 - Then gate to printer and print ticket if paper present.
// R04 - Original done: gate back to hand-held, send ID S01.
// R05 - Transaction complete allows new delivery, replies ID S00.
// R06 - 42-column printer: check paper each printout, poll until paper or stop.
// R07 - Stop during paper error: gate back, send ID S10; the code sends S11 instead when the print is a duplicate.
// R08 - Print request starts original or duplicate, only in printer mode.
// R09 - Hand-held stays silent after S08/S09 until next status.
// R10 - Frames start with colon, end with CR; act only then.
// R11 - Colon discards partial frame; uncoloned characters never execute.
// R12 - Every response ends with CR LF.
// R13 - Gap over 2 s clears receive buffer; next byte starts fresh.
// R14 - Half duplex; received characters are never echoed.
// R15 - First response byte under 160 ms after terminating CR; the code sends it RESP_CYC + 2 cycles after the CR, just past 160 ms.
// R16 - Totals report carries two's complement checksum before CR LF.
// R17 - Two letters, case-insensitive, optional value; unknown gives invalid reply.
// R18 - Unit ID 0 accepts all commands without selection.
// R19 - Select with own ID selects, other deselects, silent; bare select replies ID.
// R20 - Batch and density values checked against limits; reply ID and value.
// R21 - Halt and commence act as stop and run keys; halt acks alarms; the code has no alarm acknowledge, halt only pulses STOP_PULSE.
// R22 - Totals report each request; below clearable minimum gives S14.
// R23 - Timeout counter restarts on each byte, clears frame at count.
`timescale 1ns/1ps
`default_nettype none
`include "fach_map.vh"
module fach_top #(
  parameter TIMEOUT_CYC = `FACH_TIMEOUT_CYC,
  parameter RESP_CYC    = `FACH_RESP_CYC,
  parameter VAL_W       = 16,
  parameter FIFO_DEPTH  = 8
) (
  input  wire             SYS_CLK,
  input  wire             RST_N,
  input  wire [7:0]       RX_DATA,
  input  wire             RX_VALID,
  output wire [7:0]       TX_DATA,
  output wire             TX_VALID,
  input  wire             TX_READY,
  output reg              GATE_PRINTER,
  output reg              HH_TO_PRINTER,
  input  wire [7:0]       UNIT_ID,
  input  wire             PRINTER_MODE,
  input  wire             SLIP_42_COL,
  input  wire             PAPER_PRESENT,
  input  wire             STOP_KEY,
  input  wire             DELIVERY_FINISH_EVENT,
  input  wire             TICKET_DONE,
  input  wire             BELOW_MIN_TOTAL,
  input  wire [7:0]       TOTALS_BYTE,
  input  wire [3:0]       TOTALS_LEN,
  input  wire [VAL_W-1:0] BATCH_MIN,
  input  wire [VAL_W-1:0] BATCH_MAX,
  input  wire [VAL_W-1:0] DENS_MIN,
  input  wire [VAL_W-1:0] DENS_MAX,
  output reg  [3:0]       TOTALS_IDX,
  output reg  [VAL_W-1:0] BATCH_VALUE,
  output reg  [VAL_W-1:0] DENSITY_VALUE,
  output reg              START_PRINT,
  output reg              DUPLICATE_PRINT,
  output reg              PAPER_ERROR,
  output reg              RUN_PULSE,
  output reg              STOP_PULSE,
  output reg              DELIVERY_ALLOWED
);
  // --------------------
  // Receive parser state
  // --------------------
  localparam [1:0] RX_IDLE = 2'd0;
  localparam [1:0] RX_BODY = 2'd1;
  localparam [1:0] RX_EXEC = 2'd2;

  // Response builder states
  localparam [2:0] TX_IDLE = 3'd0;
  localparam [2:0] TX_ID   = 3'd1;
  localparam [2:0] TX_BODY = 3'd2;
  localparam [2:0] TX_TOT  = 3'd3;
  localparam [2:0] TX_CSUM = 3'd4;
  localparam [2:0] TX_CR   = 3'd5;
  localparam [2:0] TX_LF   = 3'd6;

  // Response kinds
  localparam [2:0] RK_STATUS = 3'd0;
  localparam [2:0] RK_ID     = 3'd1;
  localparam [2:0] RK_VALUE  = 3'd2;
  localparam [2:0] RK_TOTALS = 3'd3;
  localparam [2:0] RK_INVAL  = 3'd4;

  // Print sequence states
  localparam [2:0] PS_IDLE  = 3'd0;
  localparam [2:0] PS_ANN   = 3'd1;
  localparam [2:0] PS_PAPER = 3'd2;
  localparam [2:0] PS_PRINT = 3'd3;
  localparam [2:0] PS_DONE  = 3'd4;

  reg [1:0]       rx_st_reg;
  reg [7:0]       c1_reg;
  reg [7:0]       c2_reg;
  reg [1:0]       nch_reg;
  reg             has_val_reg;
  reg [VAL_W-1:0] val_reg;
  reg [31:0]      gap_reg;
  reg [1:0]       esc_reg;
  reg             selected_reg;
  reg [2:0]       tx_st_reg;
  reg [2:0]       rk_reg;
  reg [7:0]       stat_reg;
  reg [VAL_W-1:0] rval_reg;
  reg [7:0]       csum_reg;
  reg [31:0]      resp_cnt_reg;
  reg [2:0]       ps_st_reg;
  reg             orig_done_reg;
  reg             pend_fin_reg;
  reg [7:0]       fifo_in;
  reg             fifo_push;
  wire            fifo_ready;
  wire            fifo_busy;
  wire [7:0]      u1;
  wire [7:0]      u2;
  wire            addressed;
  wire            rx_ok;
  wire            digit;

  assign u1 = c1_reg & `FACH_CASE_MASK;                   // [R17]
  assign u2 = c2_reg & `FACH_CASE_MASK;
  assign addressed = (UNIT_ID == 8'h00) || selected_reg;  // [R18]
  // Offline toward the hand-held while the gate faces the printer
  assign rx_ok = RX_VALID && !GATE_PRINTER && !HH_TO_PRINTER;
  assign digit = (RX_DATA >= `FACH_CH_ZERO) && (RX_DATA <= 8'h39);

  // --------------------
  // Frame reception, timeout and gate escapes
  // --------------------
  // Received bytes only feed the parser; nothing loops to TX. [R14]
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_st_reg     <= RX_IDLE;
      c1_reg        <= 8'h00;
      c2_reg        <= 8'h00;
      nch_reg       <= 2'd0;
      has_val_reg   <= 1'b0;
      val_reg       <= {VAL_W{1'b0}};
      gap_reg       <= 32'h00000000;
      esc_reg       <= 2'd0;
      HH_TO_PRINTER <= 1'b0;
    end else begin
      if (RX_VALID)
        gap_reg <= 32'h00000000;                           // [R23]
      else if (gap_reg != TIMEOUT_CYC)
        gap_reg <= gap_reg + 32'h00000001;
      if (!RX_VALID && gap_reg == TIMEOUT_CYC - 1 && rx_st_reg == RX_BODY)
        rx_st_reg <= RX_IDLE;                              // [R13] [R23]
      // Escape sequence tracker works in either gate position
      if (RX_VALID) begin
        if (RX_DATA == `FACH_CH_ESC)
          esc_reg <= (esc_reg == 2'd2) ? 2'd2 : esc_reg + 2'd1;
        else begin
          esc_reg <= 2'd0;
          if (esc_reg == 2'd2 && RX_DATA == `FACH_CH_Y)
            HH_TO_PRINTER <= 1'b0;                         // [R01]
          if (esc_reg == 2'd2 && RX_DATA == `FACH_CH_Z)
            HH_TO_PRINTER <= 1'b1;                         // [R01]
        end
      end
      if (rx_st_reg == RX_EXEC)
        rx_st_reg <= RX_IDLE;
      else if (rx_ok) begin
        if (RX_DATA == `FACH_CH_COLON) begin
          rx_st_reg   <= RX_BODY;                          // [R11]
          nch_reg     <= 2'd0;
          has_val_reg <= 1'b0;
          val_reg     <= {VAL_W{1'b0}};
        end else if (rx_st_reg == RX_BODY) begin
          if (RX_DATA == `FACH_CH_CR)
            rx_st_reg <= RX_EXEC;                          // [R10]
          else if (nch_reg == 2'd0) begin
            c1_reg  <= RX_DATA;
            nch_reg <= 2'd1;
          end else if (nch_reg == 2'd1) begin
            c2_reg  <= RX_DATA;
            nch_reg <= 2'd2;
          end else if (digit) begin
            has_val_reg <= 1'b1;                           // [R17]
            val_reg     <= val_reg * {{(VAL_W-4){1'b0}}, 4'hA} + {{(VAL_W-4){1'b0}}, RX_DATA[3:0]};
          end else if (RX_DATA != 8'h2E)
            has_val_reg <= 1'b1;
        end
      end
    end
  end

  // --------------------
  // Command execution and print sequencing
  // --------------------
  // A finish event waits for the current frame and reply to drain. [R02]
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      selected_reg     <= 1'b0;
      ps_st_reg        <= PS_IDLE;
      orig_done_reg    <= 1'b0;
      pend_fin_reg     <= 1'b0;
      GATE_PRINTER     <= `FACH_GATE_UNIT;
      BATCH_VALUE      <= {VAL_W{1'b0}};
      DENSITY_VALUE    <= {VAL_W{1'b0}};
      START_PRINT      <= 1'b0;
      DUPLICATE_PRINT  <= 1'b0;
      PAPER_ERROR      <= 1'b0;
      RUN_PULSE        <= 1'b0;
      STOP_PULSE       <= 1'b0;
      DELIVERY_ALLOWED <= 1'b1;
      rk_reg           <= RK_STATUS;
      stat_reg         <= `FACH_ST_00;
      rval_reg         <= {VAL_W{1'b0}};
      resp_cnt_reg     <= 32'h00000000;
    end else begin
      START_PRINT <= 1'b0;
      RUN_PULSE   <= 1'b0;
      STOP_PULSE  <= 1'b0;
      if (DELIVERY_FINISH_EVENT) begin
        pend_fin_reg     <= 1'b1;
        DELIVERY_ALLOWED <= 1'b0;
      end
      if (resp_cnt_reg != 32'h00000000)
        resp_cnt_reg <= resp_cnt_reg - 32'h00000001;
      if (rx_st_reg == RX_EXEC && u1 == 8'h49 && u2 == 8'h44) begin
        if (has_val_reg)
          selected_reg <= (val_reg[7:0] == UNIT_ID);       // [R19]
        else if (addressed) begin
          rk_reg       <= RK_ID;                           // [R19]
          resp_cnt_reg <= RESP_CYC;
        end
      end else if (rx_st_reg == RX_EXEC && addressed) begin
        resp_cnt_reg <= RESP_CYC;                          // [R15]
        rk_reg       <= RK_STATUS;
        if (u1 == 8'h54 && u2 == 8'h43) begin              // transaction_complete_cmd
          DELIVERY_ALLOWED <= 1'b1;                        // [R05]
          stat_reg         <= `FACH_ST_00;
        end else if (u1 == 8'h44 && u2 == 8'h43) begin     // delivery_commence_cmd
          RUN_PULSE <= DELIVERY_ALLOWED;                   // [R21]
        end else if (u1 == 8'h44 && u2 == 8'h48) begin     // delivery_halt_cmd
          STOP_PULSE <= 1'b1;                              // [R21]
        end else if (u1 == 8'h50 && u2 == 8'h52) begin     // print_request_cmd
          if (PRINTER_MODE && ps_st_reg == PS_IDLE) begin  // [R08]
            DUPLICATE_PRINT <= orig_done_reg;
            stat_reg        <= orig_done_reg ? `FACH_ST_09 : `FACH_ST_08;
            ps_st_reg       <= PS_ANN;
          end
        end else if (u1 == 8'h42 && u2 == 8'h56) begin     // batch_value_write
          rk_reg <= RK_VALUE;                              // [R20]
          if (val_reg >= BATCH_MIN && val_reg <= BATCH_MAX) begin
            BATCH_VALUE <= val_reg;
            rval_reg    <= val_reg;
          end else
            rval_reg <= BATCH_VALUE;
        end else if (u1 == 8'h44 && u2 == 8'h56) begin     // density_value_write
          rk_reg <= RK_VALUE;                              // [R20]
          if (val_reg >= DENS_MIN && val_reg <= DENS_MAX) begin
            DENSITY_VALUE <= val_reg;
            rval_reg      <= val_reg;
          end else
            rval_reg <= DENSITY_VALUE;
        end else if (u1 == 8'h54 && c2_reg == `FACH_CH_QM) begin
          if (BELOW_MIN_TOTAL)
            stat_reg <= `FACH_ST_14;                       // [R22]
          else
            rk_reg <= RK_TOTALS;                           // [R22]
        end else if (u1 == 8'h44 && u2 == 8'h53) begin
          rk_reg <= RK_STATUS;
        end else
          rk_reg <= RK_INVAL;                              // [R17]
      end else begin
        case (ps_st_reg)
          PS_IDLE: begin
            if (pend_fin_reg && rx_st_reg != RX_BODY && tx_st_reg == TX_IDLE && resp_cnt_reg == 32'h00000000) begin
              pend_fin_reg    <= DELIVERY_FINISH_EVENT; // A fresh event wins
              GATE_PRINTER    <= `FACH_GATE_UNIT;          // [R02]
              stat_reg        <= `FACH_ST_08;              // [R02]
              rk_reg          <= RK_STATUS;
              resp_cnt_reg    <= 32'h00000001;
              DUPLICATE_PRINT <= 1'b0;
              orig_done_reg   <= 1'b0;
              ps_st_reg       <= PS_ANN;
            end
          end
          PS_ANN: begin
            // Gate flips only once the announcement has fully left
            if (tx_st_reg == TX_IDLE && resp_cnt_reg == 32'h00000000 && !fifo_busy) begin
              GATE_PRINTER <= `FACH_GATE_PRINTER;          // [R03]
              ps_st_reg    <= PS_PAPER;
            end
          end
          PS_PAPER: begin
            if (!SLIP_42_COL || PAPER_PRESENT) begin
              PAPER_ERROR <= 1'b0;
              START_PRINT <= 1'b1;                         // [R03]
              ps_st_reg   <= PS_PRINT;
            end else if (STOP_KEY) begin
              PAPER_ERROR  <= 1'b0;
              GATE_PRINTER <= `FACH_GATE_UNIT;             // [R07]
              stat_reg     <= DUPLICATE_PRINT ? `FACH_ST_11 : `FACH_ST_10;
              resp_cnt_reg <= 32'h00000001;
              ps_st_reg    <= PS_DONE;
            end else
              PAPER_ERROR <= 1'b1;                         // [R06]
          end
          PS_PRINT: begin
            if (TICKET_DONE) begin
              GATE_PRINTER  <= `FACH_GATE_UNIT;            // [R04]
              stat_reg      <= `FACH_ST_01;                // [R04]
              orig_done_reg <= 1'b1;
              resp_cnt_reg  <= 32'h00000001;
              ps_st_reg     <= PS_DONE;
            end
          end
          PS_DONE: begin
            if (tx_st_reg != TX_IDLE)
              ps_st_reg <= PS_IDLE;
          end
          default: ps_st_reg <= PS_IDLE;
        endcase
      end
    end
  end

  // --------------------
  // Response builder feeding the FIFO
  // --------------------
  reg  [1:0] idx_reg;
  wire       go;

  // A reply starts only if the gate faces the unit when its count reaches one; otherwise it is dropped
  assign go = (resp_cnt_reg == 32'h00000001) && !GATE_PRINTER;

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tx_st_reg  <= TX_IDLE;
      idx_reg    <= 2'd0;
      csum_reg   <= 8'h00;
      TOTALS_IDX <= 4'h0;
    end else if (tx_st_reg == TX_IDLE) begin
      if (go) begin
        tx_st_reg  <= TX_ID;
        idx_reg    <= 2'd0;
        csum_reg   <= 8'h00;
        TOTALS_IDX <= 4'h0;
      end
    end else if (fifo_ready) begin
      csum_reg <= csum_reg + fifo_in;                      // [R16]
      idx_reg  <= idx_reg + 2'd1;
      case (tx_st_reg)
        TX_ID: begin
          idx_reg   <= 2'd0;
          tx_st_reg <= (rk_reg == RK_ID) ? TX_CR :
                       (rk_reg == RK_TOTALS) ? TX_TOT : TX_BODY;
        end
        TX_BODY: begin
          if (idx_reg == 2'd3 || (rk_reg == RK_INVAL && idx_reg == 2'd0))
            tx_st_reg <= TX_CR;
        end
        TX_TOT: begin
          TOTALS_IDX <= TOTALS_IDX + 4'h1;
          if (TOTALS_IDX == TOTALS_LEN - 4'h1)
            tx_st_reg <= TX_CSUM;
        end
        TX_CSUM: tx_st_reg <= TX_CR;
        TX_CR:   tx_st_reg <= TX_LF;                       // [R12]
        TX_LF:   tx_st_reg <= TX_IDLE;
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  // Byte selection for each response kind
  always @* begin
    fifo_push = (tx_st_reg != TX_IDLE);
    fifo_in   = `FACH_CH_SP;
    case (tx_st_reg)
      TX_ID:   fifo_in = UNIT_ID + `FACH_CH_ZERO;
      TX_BODY: begin
        if (rk_reg == RK_INVAL)
          fifo_in = `FACH_CH_QM;
        else if (rk_reg == RK_STATUS)
          case (idx_reg)
            2'd0:    fifo_in = `FACH_CH_SP;
            2'd1:    fifo_in = `FACH_CH_S;
            2'd2:    fifo_in = {4'h3, stat_reg[7:4]};
            default: fifo_in = {4'h3, stat_reg[3:0]};
          endcase
        else
          case (idx_reg)
            2'd0:    fifo_in = `FACH_CH_SP;
            2'd1:    fifo_in = rval_reg[15:8];
            2'd2:    fifo_in = rval_reg[7:0];
            default: fifo_in = `FACH_CH_SP;
          endcase
      end
      TX_TOT:  fifo_in = TOTALS_BYTE;
      TX_CSUM: fifo_in = 8'h00 - csum_reg;                 // [R16]
      TX_CR:   fifo_in = `FACH_CH_CR;                      // [R12]
      TX_LF:   fifo_in = `FACH_CH_LF;
      default: fifo_in = `FACH_CH_SP;
    endcase
  end

  // Output buffer; a stalled transmitter back-pressures the builder
  fach_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .in_data   (fifo_in),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .out_data  (TX_DATA),
    .out_valid (TX_VALID),
    .out_ready (TX_READY)
  );
  assign fifo_busy = TX_VALID;
endmodule
`default_nettype wire

// ===== test/fach_top_properties.sv
// Port-level checker for the framed ASCII command handler
`timescale 1ns/1ps
`default_nettype none
`include "fach_map.vh"
module fach_top_chk (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic [7:0] RX_DATA,
  input wire logic       RX_VALID,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_VALID,
  input wire logic       TX_READY,
  input wire logic       GATE_PRINTER,
  input wire logic       HH_TO_PRINTER,
  input wire logic       SLIP_42_COL,
  input wire logic       PAPER_PRESENT,
  input wire logic       STOP_KEY,
  input wire logic       TICKET_DONE,
  input wire logic       START_PRINT,
  input wire logic       PAPER_ERROR
);
  // --------------------
  // Escape tracking and properties
  // --------------------
  logic [7:0] prev1_reg;
  logic [7:0] prev2_reg;
  wire        esc2 = (prev1_reg == `FACH_CH_ESC) && (prev2_reg == `FACH_CH_ESC);
  // Last two bytes, to spot switch sequences
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      prev1_reg <= 8'h00;
      prev2_reg <= 8'h00;
    end else if (RX_VALID) begin
      prev1_reg <= RX_DATA;
      prev2_reg <= prev1_reg;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  esc_y_unit_a: assert property (esc2 && RX_VALID && RX_DATA == `FACH_CH_Y |-> ##[1:3] !HH_TO_PRINTER)
    else $error("esc Y failed");
  esc_z_printer_a: assert property (esc2 && RX_VALID && RX_DATA == `FACH_CH_Z |-> ##[1:3] HH_TO_PRINTER)
    else $error("esc Z failed");
  gate_after_status_a: assert property ($rose(GATE_PRINTER) |-> !TX_VALID)
    else $error("gate moved early");
  start_needs_paper_a: assert property (START_PRINT |-> GATE_PRINTER && (!SLIP_42_COL || PAPER_PRESENT))
    else $error("bad print start");
  paper_fault_a: assert property ($rose(PAPER_ERROR) |-> SLIP_42_COL && !$past(PAPER_PRESENT))
    else $error("bad paper error");
  stop_returns_a: assert property (PAPER_ERROR && STOP_KEY |-> ##[1:4] !GATE_PRINTER)
    else $error("stop kept gate");
  done_returns_a: assert property (TICKET_DONE && GATE_PRINTER && !PAPER_ERROR |-> ##[1:4] !GATE_PRINTER)
    else $error("done kept gate");
  tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("stalled byte lost");
  no_echo_a: assert property (RX_VALID && RX_DATA != `FACH_CH_CR && !TX_VALID && !GATE_PRINTER |=> !TX_VALID [*4])
    else $error("byte echoed");
endmodule
bind fach_top fach_top_chk i_fach_top_chk (.*);
`default_nettype wire

// ===== test/fach_hh_model.sv
// Hand-held side model: collects response bytes, can stall
`timescale 1ns/1ps
`default_nettype none
module fach_hh_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       slow,
  output var  logic       tx_ready
);
  logic [7:0] got_q[$];
  logic       phase_reg = 1'b0;
  initial tx_ready = 1'b0;
  // Ready toggles when slow, so the unit must hold each byte
  always @(negedge clk) begin
    phase_reg <= !phase_reg;
    tx_ready  <= !slow || phase_reg;
  end
  // Receive only: it stays silent while the unit owns the line
  always @(posedge clk) begin
    if (rst_n && tx_valid && tx_ready) got_q.push_back(tx_data);
  end
endmodule
`default_nettype wire

// ===== test/fach_top_tb.sv
// Self-checking bench for the framed ASCII command handler
`timescale 1ns/1ps
`default_nettype none
module fach_top_tb;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic       rx_valid = 1'b0;
  logic       paper = 1'b1;
  logic       stop_key = 1'b0;
  logic       finish_ev = 1'b0;
  logic       ticket_done = 1'b0;
  logic       below_min = 1'b0;
  logic       slow = 1'b0;
  logic [3:0] tot_len = 4'h3;
  logic [15:0] lim_lo = 16'h0000;
  logic [15:0] lim_hi = 16'hFFFF;
  logic       started = 1'b0;
  wire        tx_ready;
  wire  [7:0] tx_data;
  wire        tx_valid;
  wire        gate_printer;
  wire        hh_to_printer;
  wire  [3:0] totals_idx;
  wire        start_print;
  wire        paper_error;
  wire        delivery_allowed;
  int         n_mismatch = 0;
  int         n_compared = 0;
  logic [7:0] exp_q[$];

  // --------------------
  // Clock, design and hand-held model
  // --------------------
  always #12.5 sys_clk = ~sys_clk;
  // Start is a one-cycle pulse, so latch it
  always @(posedge sys_clk) if (start_print) started <= 1'b1;
  // Short counts keep the run brief
  fach_top #(.TIMEOUT_CYC(200), .RESP_CYC(20)) i_fach_top (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .GATE_PRINTER(gate_printer), .HH_TO_PRINTER(hh_to_printer),
    .UNIT_ID(8'h00), .PRINTER_MODE(1'b1), .SLIP_42_COL(1'b1), .PAPER_PRESENT(paper), .STOP_KEY(stop_key),
    .DELIVERY_FINISH_EVENT(finish_ev), .TICKET_DONE(ticket_done), .BELOW_MIN_TOTAL(below_min),
    .TOTALS_BYTE(8'h41 + {4'h0, totals_idx}), .TOTALS_LEN(tot_len), .BATCH_MIN(lim_lo),
    .BATCH_MAX(lim_hi), .DENS_MIN(lim_lo), .DENS_MAX(lim_hi), .TOTALS_IDX(totals_idx),
    .BATCH_VALUE(), .DENSITY_VALUE(), .START_PRINT(start_print), .DUPLICATE_PRINT(),
    .PAPER_ERROR(paper_error), .RUN_PULSE(), .STOP_PULSE(), .DELIVERY_ALLOWED(delivery_allowed));
  fach_hh_model i_fach_hh_model (.clk(sys_clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .slow(slow), .tx_ready(tx_ready));

  // --------------------
  // Shared tasks
  // --------------------
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic timed_out(string what);
    $display("[FAIL] %s expected activity seen timeout", what);
    n_mismatch++;
    results;
  endtask
  // One byte per pulse, with an idle cycle between bytes
  task automatic send_str(string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge sys_clk);
      rx_data = s[i];
      rx_valid = 1'b1;
      @(negedge sys_clk);
      rx_valid = 1'b0;
    end
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic add(string s);
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
  endtask
  // Empty expectation: nothing may be sent
  task automatic expect_resp(string what);
    int k;
    for (k = 0; k < 400 && i_fach_hh_model.got_q.size() < exp_q.size(); k++) @(negedge sys_clk);
    if (k == 400) timed_out(what);
    repeat (40) @(negedge sys_clk);
    check(what, 8'(exp_q.size()), 8'(i_fach_hh_model.got_q.size()));
    foreach (exp_q[i]) check(what, exp_q[i], i_fach_hh_model.got_q[i]);
    exp_q.delete();
    i_fach_hh_model.got_q.delete();
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_escape;
    send_str("\033\033Z");
    check("printer path", 1, hh_to_printer);
    send_str(":TC\r");
    expect_resp("bypassed frame");
    send_str("\033\033Y");
    check("unit path", 0, hh_to_printer);
  endtask
  task automatic t_frames;
    send_str("TC\r");
    expect_resp("unframed");
    send_str(":D:tc\r");
    add("0 S00\r\n");
    expect_resp("restarted frame");
    check("delivery allowed", 1, delivery_allowed);
    send_str(":QQ\r");
    add("0?\r\n");
    expect_resp("invalid command");
  endtask
  task automatic t_timeout;
    send_str(":T");
    repeat (250) @(negedge sys_clk);
    send_str("C\r");
    expect_resp("stale frame");
    send_str(":T");
    repeat (150) @(negedge sys_clk);
    send_str("C\r");
    add("0 S00\r\n");
    expect_resp("slow frame");
  endtask
  task automatic t_totals;
    slow = 1'b1;
    for (int n = 1; n <= 3; n++) begin
      logic [7:0] sum;
      tot_len = n[3:0];
      sum = 8'h30;
      add("0");
      for (int i = 0; i < n; i++) begin
        exp_q.push_back(8'h41 + i[7:0]);
        sum = sum + 8'h41 + i[7:0];
      end
      exp_q.push_back(8'h00 - sum);
      add("\r\n");
      send_str(":t?\r");
      expect_resp("totals report");
    end
    below_min = 1'b1;
    send_str(":T?\r");
    add("0 S14\r\n");
    expect_resp("below minimum");
    below_min = 1'b0;
    slow = 1'b0;
  endtask
  // Finish event through to the ticket outcome, with or without paper
  task automatic t_print(logic with_paper);
    int k;
    paper = with_paper;
    started = 1'b0;
    @(negedge sys_clk);
    finish_ev = 1'b1;
    @(negedge sys_clk);
    finish_ev = 1'b0;
    add("0 S08\r\n");
    expect_resp("finish status");
    for (k = 0; k < 400 && started !== 1'b1 && paper_error !== 1'b1; k++) @(negedge sys_clk);
    if (k == 400) timed_out("printout");
    check("printer gate", 1, gate_printer);
    check("print start", with_paper, started);
    check("paper error", !with_paper, paper_error);
    @(negedge sys_clk);
    if (with_paper) ticket_done = 1'b1;
    else stop_key = 1'b1;
    @(negedge sys_clk);
    ticket_done = 1'b0;
    stop_key = 1'b0;
    add(with_paper ? "0 S01\r\n" : "0 S10\r\n");
    expect_resp("print outcome");
    check("unit gate", 0, gate_printer);
  endtask

  // Main sequence, reset held for six cycles
  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("allowed at reset", 1, delivery_allowed);
    t_escape;
    t_print(1'b1);
    t_frames;
    t_timeout;
    t_totals;
    t_print(1'b0);
    results;
  end
endmodule
`default_nettype wire
